// *** include/rab_defines.vh ***
`ifndef RAB_DEFINES_VH
`define RAB_DEFINES_VH
// Behaviour
// - binary start address is plain logical value
// - ascii start address converted from hex characters
// - length counts 16-bit words inside buffer
// - binary word count at most 1017
// - ascii word count at most 508
// - response end code also kept in end code register
// - write answer is subheader plus end code
// - read command field order and byte order
// - logical addresses map onto cpu physical addresses
// - cpu cannot send nor see receive completion
// - serve only after init and open done
// - default router plus eight entries, no forwarding
// - relay selectable, mask accepted only in range
// - unsubnetted mask equals class default mask
// - default router validity checks on write
// - unmatched destination goes via default router
// - table destination class A/B/C, host zero
// - only on handshaked connections with open done

// command subheaders and response marker
`define RAB_SUB_RD 8'h61
`define RAB_SUB_WR 8'h62
`define RAB_RSP_BIT 8'h80

// word count limits per coding
`define RAB_MAX_BIN 16'h03f9
`define RAB_MAX_ASC 16'h01fc

// end codes
`define RAB_EC_OK 8'h00
`define RAB_EC_LEN 8'h51
`define RAB_EC_RANGE 8'h52
`define RAB_EC_SUB 8'h53
`define RAB_EC_CHAR 8'h54

// field sequencing
`define RAB_F_SUB 2'h0
`define RAB_F_ADDR 2'h1
`define RAB_F_LEN 2'h2
`define RAB_BIN_LAST 2'h1
`define RAB_ASC_LAST 2'h3
`define RAB_BIN_BYTE_N 3'h1
`define RAB_ASC_BYTE_N 3'h2
`define RAB_BIN_WORD_N 3'h2
`define RAB_ASC_WORD_N 3'h4
`define RAB_IT_SUB 2'h0
`define RAB_IT_END 2'h1
`define RAB_IT_WORD 2'h2

// cpu port map outside the buffer window
`define RAB_A_CTRL 16'hf000
`define RAB_A_MASK 16'hf001
`define RAB_A_OWN 16'hf002
`define RAB_A_DFLT 16'hf003
`define RAB_A_STAT 16'hf004
`define RAB_A_ENDC 16'hf005
`define RAB_A_RT_PAGE 12'hf01
`define RAB_CTRL_RELAY 0
`define RAB_ST_REJ_MASK 0
`define RAB_ST_REJ_DFLT 1
`define RAB_ST_REJ_RT 2
`define RAB_ST_DFLT_V 3
`define RAB_ST_RT_V 8

// subnet mask range and class masks
`define RAB_MASK_MIN 32'hc0000000
`define RAB_MASK_MAX 32'hfffffffc
`define RAB_CLS_A 32'hff000000
`define RAB_CLS_B 32'hffff0000
`define RAB_CLS_C 32'hffffff00

// ascii hex characters
`define RAB_CH_0 8'h30
`define RAB_CH_9 8'h39
`define RAB_CH_UA 8'h41
`define RAB_CH_UF 8'h46
`define RAB_CH_LA 8'h61
`define RAB_CH_LF 8'h66
`define RAB_CH_OFS 8'h0a
`endif

// *** hw/hex_ascii_conv.v ***
`timescale 1ns/1ps
`include "rab_defines.vh"
module hex_ascii_conv (
	// character to nibble
	input wire [7:0] i_char,
	output reg [3:0] o_nib,
	output reg o_char_ok,
	// nibble to upper-case character
	input wire [3:0] i_nib,
	output wire [7:0] o_char
);
	wire [7:0] up_val = i_char - `RAB_CH_UA + `RAB_CH_OFS;
	wire [7:0] lo_val = i_char - `RAB_CH_LA + `RAB_CH_OFS;
	wire [7:0] dg_val = i_char - `RAB_CH_0;

	always @* begin
		o_nib = 4'h0;
		o_char_ok = 1'b1;
		if (i_char >= `RAB_CH_0 && i_char <= `RAB_CH_9)
			o_nib = dg_val[3:0];
		else if (i_char >= `RAB_CH_UA && i_char <= `RAB_CH_UF)
			o_nib = up_val[3:0];
		else if (i_char >= `RAB_CH_LA && i_char <= `RAB_CH_LF)
			o_nib = lo_val[3:0];
		else
			o_char_ok = 1'b0;
	end

	assign o_char = (i_nib < 4'ha) ? (`RAB_CH_0 + {4'h0, i_nib}) :
		(`RAB_CH_UA + {4'h0, i_nib} - `RAB_CH_OFS);
endmodule // hex_ascii_conv

// *** hw/random_access_buffer_server.v ***
`timescale 1ns/1ps
`include "rab_defines.vh"
module random_access_buffer_server #(
	parameter DEPTH = 4096,
	parameter AW = 12,
	parameter [15:0] PHYS_BASE = 16'h0000,
	parameter N_RT = 8
) (
	// clock, reset, enable
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_ce,
	// connection status
	input wire i_init_done,
	input wire i_open_done,
	input wire i_proc_exist,
	input wire i_ascii_mode,
	// command byte stream
	input wire i_rx_valid,
	input wire [7:0] i_rx_data,
	input wire i_rx_last,
	output wire o_rx_ready,
	// response byte stream
	output wire o_tx_valid,
	output wire [7:0] o_tx_data,
	output wire o_tx_last,
	input wire i_tx_ready,
	// cpu register and buffer port
	input wire [15:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output wire [31:0] o_rdata,
	// next hop lookup
	input wire [31:0] i_dest_ip,
	output wire [31:0] o_next_hop,
	output wire o_via_router
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_HDR = 3'h1;
	localparam [2:0] S_TEXT = 3'h2;
	localparam [2:0] S_DROP = 3'h3;
	localparam [2:0] S_SUB = 3'h4;
	localparam [2:0] S_SEND = 3'h5;
	localparam [2:0] S_FETCH = 3'h6;
	localparam [2:0] S_LOAD = 3'h7;
	localparam [16:0] DEPTH_W = DEPTH[16:0];

	function [31:0] cls_mask;
		input [31:0] ip;
		begin
			casez (ip[31:29])
			3'b0??: cls_mask = `RAB_CLS_A;
			3'b10?: cls_mask = `RAB_CLS_B;
			3'b110: cls_mask = `RAB_CLS_C;
			default: cls_mask = 32'h00000000;
			endcase
		end
	endfunction

	// same class as own station: subnet mask applies, else the peer's class mask
	function [31:0] net_mask;
		input [31:0] d;
		input [31:0] own;
		input [31:0] m;
		begin
			net_mask = (cls_mask(d) == cls_mask(own)) ? m : cls_mask(d);
		end
	endfunction

	function gw_ok;
		input [31:0] ip;
		input [31:0] m;
		input [31:0] own;
		begin
			gw_ok = (ip != 32'h00000000) && (ip != 32'hffffffff) &&
				(cls_mask(ip) != 32'h00000000) && ((ip & m) == (own & m)) &&
				((ip & ~m) != 32'h00000000) && ((ip & ~m) != ~m);
		end
	endfunction

	reg [2:0] st_ff;
	reg asc_ff;
	reg silent_ff;
	reg bad_ff;
	reg [1:0] fld_ff;
	reg [1:0] cnt_ff;
	reg [15:0] acc_ff;
	reg [7:0] cmd_ff;
	reg [15:0] addr_ff;
	reg [15:0] wptr_ff;
	reg [15:0] left_ff;
	reg [7:0] ec_ff;
	reg [7:0] endc_ff;
	reg tx_val_ff;
	reg [7:0] tx_dat_ff;
	reg tx_last_ff;
	reg [15:0] sh_ff;
	reg [2:0] nun_ff;
	reg [1:0] item_ff;
	reg [15:0] buf_mem [0:DEPTH-1];
	reg [15:0] cpu_q_ff;
	reg [15:0] eng_q_ff;
	reg rd_v_ff;
	reg rd_mem_ff;
	reg [31:0] reg_q_ff;
	reg relay_ff;
	reg [31:0] mask_ff;
	reg [31:0] own_ff;
	reg [31:0] dflt_ff;
	reg dflt_v_ff;
	reg [2:0] rej_ff;
	reg [31:0] rt_dest_ff [0:N_RT-1];
	reg [31:0] rt_gw_ff [0:N_RT-1];
	reg [N_RT-1:0] rt_dv_ff;
	reg [N_RT-1:0] rt_gv_ff;
	reg [31:0] hop_ff;
	reg via_ff;
	reg [31:0] reg_val;
	reg [7:0] ec_hdr;
	reg [31:0] gw_sel;
	reg gw_any;
	reg [2:0] nxt_rej;
	integer k;
	integer j;

	wire [3:0] rx_nib;
	wire rx_char_ok;
	wire [7:0] hex_char;
	hex_ascii_conv u_hex (
		.i_char(i_rx_data),
		.o_nib(rx_nib),
		.o_char_ok(rx_char_ok),
		.i_nib(sh_ff[15:12]),
		.o_char(hex_char)
	);

	wire rx_state = (st_ff == S_HDR) || (st_ff == S_TEXT) || (st_ff == S_DROP);
	// engine stalls for cpu writes so the buffer has one write port
	assign o_rx_ready = rx_state & ~i_wr & i_ce;
	wire take = i_rx_valid & o_rx_ready;
	wire [15:0] acc_n = asc_ff ? {acc_ff[11:0], rx_nib} : {i_rx_data, acc_ff[15:8]};
	wire bad_n = bad_ff | (asc_ff & ~rx_char_ok);
	wire unit_last = (cnt_ff == (asc_ff ? `RAB_ASC_LAST : `RAB_BIN_LAST));
	wire [7:0] code_n = asc_ff ? acc_n[15:8] : acc_n[7:0];
	wire [16:0] end_sum = {1'b0, addr_ff} + {1'b0, acc_n};
	wire [15:0] max_len = asc_ff ? `RAB_MAX_ASC : `RAB_MAX_BIN;
	wire last_len = (st_ff == S_HDR) && unit_last && (fld_ff == `RAB_F_LEN);
	wire eng_we = take && (st_ff == S_TEXT) && unit_last && (left_ff != 16'h0000) && !bad_n;
	wire slot_free = ~tx_val_ff | i_tx_ready;
	wire rd_more = (cmd_ff == `RAB_SUB_RD) && (ec_ff == `RAB_EC_OK) && (left_ff != 16'h0000);
	wire more_after = (item_ff == `RAB_IT_SUB) ? 1'b1 :
		((item_ff == `RAB_IT_END) ? rd_more : (left_ff != 16'h0000));
	wire [7:0] rsp_byte = cmd_ff | `RAB_RSP_BIT;

	always @* begin
		ec_hdr = `RAB_EC_OK;
		if (cmd_ff != `RAB_SUB_RD && cmd_ff != `RAB_SUB_WR)
			ec_hdr = `RAB_EC_SUB;
		else if (bad_n)
			ec_hdr = `RAB_EC_CHAR;
		else if (acc_n == 16'h0000 || acc_n > max_len)
			ec_hdr = `RAB_EC_LEN;
		else if (end_sum > DEPTH_W)
			ec_hdr = `RAB_EC_RANGE;
	end

	// only the command engine sources responses
	assign o_tx_valid = tx_val_ff;
	assign o_tx_data = tx_dat_ff;
	assign o_tx_last = tx_last_ff;

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= S_IDLE;
			asc_ff <= 1'b0;
			silent_ff <= 1'b0;
			bad_ff <= 1'b0;
			fld_ff <= `RAB_F_SUB;
			cnt_ff <= 2'h0;
			acc_ff <= 16'h0000;
			cmd_ff <= 8'h00;
			addr_ff <= 16'h0000;
			wptr_ff <= 16'h0000;
			left_ff <= 16'h0000;
			ec_ff <= `RAB_EC_OK;
			endc_ff <= `RAB_EC_OK;
			tx_val_ff <= 1'b0;
			tx_dat_ff <= 8'h00;
			tx_last_ff <= 1'b0;
			sh_ff <= 16'h0000;
			nun_ff <= 3'h0;
			item_ff <= `RAB_IT_SUB;
		end else if (i_ce) begin
			if (tx_val_ff && i_tx_ready) begin
				tx_val_ff <= 1'b0;
				tx_last_ff <= 1'b0;
			end
			if (take) begin
				acc_ff <= acc_n;
				bad_ff <= bad_n;
				cnt_ff <= unit_last ? 2'h0 : cnt_ff + 2'h1;
			end
			case (st_ff)
			S_IDLE: if (i_rx_valid) begin
				asc_ff <= i_ascii_mode;
				fld_ff <= `RAB_F_SUB;
				cnt_ff <= 2'h0;
				bad_ff <= 1'b0;
				acc_ff <= 16'h0000;
				silent_ff <= ~(i_init_done & i_open_done & i_proc_exist);
				st_ff <= (i_init_done & i_open_done & i_proc_exist) ? S_HDR : S_DROP;
			end
			S_HDR: if (take) begin
				if (unit_last) begin
					fld_ff <= fld_ff + 2'h1;
					if (fld_ff == `RAB_F_SUB)
						cmd_ff <= code_n;
					if (fld_ff == `RAB_F_ADDR)
						addr_ff <= acc_n;
				end
				if (last_len) begin
					left_ff <= acc_n;
					wptr_ff <= addr_ff;
					ec_ff <= ec_hdr;
					if (i_rx_last)
						st_ff <= S_SUB;
					else if (ec_hdr != `RAB_EC_OK || cmd_ff == `RAB_SUB_RD)
						st_ff <= S_DROP;
					else
						st_ff <= S_TEXT;
				end else if (i_rx_last) begin
					ec_ff <= `RAB_EC_LEN;
					st_ff <= S_SUB;
				end
			end
			S_TEXT: if (take) begin
				if (eng_we) begin
					wptr_ff <= wptr_ff + 16'h0001;
					left_ff <= left_ff - 16'h0001;
				end
				if (bad_n && !bad_ff)
					ec_ff <= `RAB_EC_CHAR;
				if (i_rx_last)
					st_ff <= S_SUB;
			end
			S_DROP: if (take && i_rx_last) begin
				st_ff <= silent_ff ? S_IDLE : S_SUB;
			end
			S_SUB: begin
				endc_ff <= ec_ff;
				sh_ff <= asc_ff ? {rsp_byte, 8'h00} : {8'h00, rsp_byte};
				nun_ff <= asc_ff ? `RAB_ASC_BYTE_N : `RAB_BIN_BYTE_N;
				item_ff <= `RAB_IT_SUB;
				st_ff <= S_SEND;
			end
			S_SEND: begin
				if (nun_ff != 3'h0) begin
					if (slot_free) begin
						tx_val_ff <= 1'b1;
						tx_dat_ff <= asc_ff ? hex_char : sh_ff[7:0];
						sh_ff <= asc_ff ? {sh_ff[11:0], 4'h0} : {8'h00, sh_ff[15:8]};
						nun_ff <= nun_ff - 3'h1;
						tx_last_ff <= (nun_ff == 3'h1) && !more_after;
					end
				end else if (item_ff == `RAB_IT_SUB) begin
					sh_ff <= asc_ff ? {ec_ff, 8'h00} : {8'h00, ec_ff};
					nun_ff <= asc_ff ? `RAB_ASC_BYTE_N : `RAB_BIN_BYTE_N;
					item_ff <= `RAB_IT_END;
				end else if (item_ff == `RAB_IT_END ? rd_more : (left_ff != 16'h0000)) begin
					st_ff <= S_FETCH;
				end else if (slot_free) begin
					st_ff <= S_IDLE;
				end
			end
			S_FETCH: begin
				wptr_ff <= wptr_ff + 16'h0001;
				left_ff <= left_ff - 16'h0001;
				st_ff <= S_LOAD;
			end
			S_LOAD: begin
				sh_ff <= eng_q_ff;
				nun_ff <= asc_ff ? `RAB_ASC_WORD_N : `RAB_BIN_WORD_N;
				item_ff <= `RAB_IT_WORD;
				st_ff <= S_SEND;
			end
			default: st_ff <= S_IDLE;
			endcase
		end
	end

	// physical address minus base gives logical index
	wire [16:0] cpu_off = {1'b0, i_addr} - {1'b0, PHYS_BASE};
	wire buf_hit = (i_addr >= PHYS_BASE) && (cpu_off < DEPTH_W);
	wire [AW-1:0] cpu_idx = cpu_off[AW-1:0];
	wire [AW-1:0] eng_idx = wptr_ff[AW-1:0];

	// completion flags are plain buffer words to this logic
	always @(posedge i_ref_clk) begin
		if (i_ce) begin
			if (i_wr && buf_hit)
				buf_mem[cpu_idx] <= i_wdata[15:0];
			else if (eng_we)
				buf_mem[eng_idx] <= acc_n;
			cpu_q_ff <= buf_mem[cpu_idx];
			eng_q_ff <= buf_mem[eng_idx];
		end
	end

	wire rt_page = (i_addr[15:4] == `RAB_A_RT_PAGE);
	wire [2:0] rt_idx = i_addr[3:1];

	always @* begin
		reg_val = 32'h00000000;
		case (i_addr)
		`RAB_A_CTRL: reg_val[`RAB_CTRL_RELAY] = relay_ff;
		`RAB_A_MASK: reg_val = mask_ff;
		`RAB_A_OWN: reg_val = own_ff;
		`RAB_A_DFLT: reg_val = dflt_ff;
		`RAB_A_STAT: begin
			reg_val[`RAB_ST_REJ_MASK] = rej_ff[`RAB_ST_REJ_MASK];
			reg_val[`RAB_ST_REJ_DFLT] = rej_ff[`RAB_ST_REJ_DFLT];
			reg_val[`RAB_ST_REJ_RT] = rej_ff[`RAB_ST_REJ_RT];
			reg_val[`RAB_ST_DFLT_V] = dflt_v_ff;
			reg_val[`RAB_ST_RT_V +: N_RT] = rt_dv_ff & rt_gv_ff;
		end
		`RAB_A_ENDC: reg_val[7:0] = endc_ff;
		default: if (rt_page)
			reg_val = i_addr[0] ? rt_gw_ff[rt_idx] : rt_dest_ff[rt_idx];
		endcase
	end

	// reject flags: a rejected write in the clearing cycle still sets its flag
	always @* begin
		nxt_rej = rej_ff;
		if (i_wr && i_addr == `RAB_A_STAT)
			nxt_rej = rej_ff & ~i_wdata[2:0];
		if (i_wr && i_addr == `RAB_A_MASK &&
				!(i_wdata >= `RAB_MASK_MIN && i_wdata <= `RAB_MASK_MAX))
			nxt_rej[`RAB_ST_REJ_MASK] = 1'b1;
		if (i_wr && i_addr == `RAB_A_DFLT && !gw_ok(i_wdata, mask_ff, own_ff))
			nxt_rej[`RAB_ST_REJ_DFLT] = 1'b1;
		if (i_wr && rt_page && (i_addr[0] ? !gw_ok(i_wdata, mask_ff, own_ff) :
				!((cls_mask(i_wdata) != 32'h00000000) &&
				((i_wdata & ~net_mask(i_wdata, own_ff, mask_ff)) == 32'h00000000))))
			nxt_rej[`RAB_ST_REJ_RT] = 1'b1;
	end

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_v_ff <= 1'b0;
			rd_mem_ff <= 1'b0;
			reg_q_ff <= 32'h00000000;
			relay_ff <= 1'b0;
			mask_ff <= `RAB_CLS_C;
			own_ff <= 32'h00000000;
			dflt_ff <= 32'h00000000;
			dflt_v_ff <= 1'b0;
			rej_ff <= 3'h0;
			rt_dv_ff <= {N_RT{1'b0}};
			rt_gv_ff <= {N_RT{1'b0}};
			for (k = 0; k < N_RT; k = k + 1) begin
				rt_dest_ff[k] <= 32'h00000000;
				rt_gw_ff[k] <= 32'h00000000;
			end
		end else if (i_ce) begin
			rd_v_ff <= i_rd;
			rd_mem_ff <= buf_hit;
			reg_q_ff <= reg_val;
			rej_ff <= nxt_rej;
			if (i_wr) begin
				if (i_addr == `RAB_A_CTRL)
					relay_ff <= i_wdata[`RAB_CTRL_RELAY];
				if (i_addr == `RAB_A_MASK && !nxt_rej[`RAB_ST_REJ_MASK])
					mask_ff <= i_wdata;
				if (i_addr == `RAB_A_OWN)
					own_ff <= i_wdata;
				if (i_addr == `RAB_A_DFLT && !nxt_rej[`RAB_ST_REJ_DFLT]) begin
					dflt_ff <= i_wdata;
					dflt_v_ff <= 1'b1;
				end
				if (rt_page && !nxt_rej[`RAB_ST_REJ_RT]) begin
					if (i_addr[0]) begin
						rt_gw_ff[rt_idx] <= i_wdata;
						rt_gv_ff[rt_idx] <= 1'b1;
					end else begin
						rt_dest_ff[rt_idx] <= i_wdata;
						rt_dv_ff[rt_idx] <= 1'b1;
					end
				end
			end
		end
	end

	assign o_rdata = rd_v_ff ? (rd_mem_ff ? {16'h0000, cpu_q_ff} : reg_q_ff) : 32'h00000000;

	wire [N_RT-1:0] rt_hit;
	genvar g;
	generate
		for (g = 0; g < N_RT; g = g + 1) begin : g_rt
			assign rt_hit[g] = rt_dv_ff[g] & rt_gv_ff[g] &
				((i_dest_ip & net_mask(rt_dest_ff[g], own_ff, mask_ff)) == rt_dest_ff[g]);
		end
	endgenerate

	always @* begin
		gw_sel = 32'h00000000;
		gw_any = 1'b0;
		for (j = N_RT - 1; j >= 0; j = j - 1) begin
			if (rt_hit[j]) begin
				gw_sel = rt_gw_ff[j];
				gw_any = 1'b1;
			end
		end
	end

	wire local_net = ((i_dest_ip & mask_ff) == (own_ff & mask_ff));

	// only picks a next hop, never relays frames
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hop_ff <= 32'h00000000;
			via_ff <= 1'b0;
		end else if (i_ce) begin
			hop_ff <= i_dest_ip;
			via_ff <= 1'b0;
			if (relay_ff && !local_net) begin
				if (gw_any) begin
					hop_ff <= gw_sel;
					via_ff <= 1'b1;
				end else if (dflt_v_ff) begin
					hop_ff <= dflt_ff;
					via_ff <= 1'b1;
				end
			end
		end
	end

	assign o_next_hop = hop_ff;
	assign o_via_router = via_ff;
endmodule // random_access_buffer_server

// *** tb/rab_props.sv ***
`timescale 1ns/1ps
module rab_props (
	// clock and status
	input wire i_ref_clk,
	input wire i_rst_n,
	input wire i_init_done,
	input wire i_open_done,
	input wire i_proc_exist,
	input wire i_ascii_mode,
	// streams
	input wire i_rx_valid,
	input wire o_rx_ready,
	input wire o_tx_valid,
	input wire [7:0] o_tx_data,
	input wire o_tx_last,
	input wire i_tx_ready,
	// cpu port and lookup
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	input wire [31:0] i_dest_ip,
	input wire [31:0] o_next_hop,
	input wire o_via_router
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data seen outside its cycle");
	chk_ready_wr: assert property (i_wr |-> !o_rx_ready)
		else $error("command taken during cpu write");
	chk_one_frame: assert property (o_tx_valid |-> !o_rx_ready)
		else $error("command taken while answering");
	chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
		o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
		else $error("response byte dropped while stalled");
	chk_last_valid: assert property (o_tx_last |-> o_tx_valid)
		else $error("last flag without valid");
	chk_serve_gate: assert property (o_tx_valid |-> i_init_done && i_open_done && i_proc_exist)
		else $error("answer while not open");
	chk_ascii_chars: assert property (o_tx_valid && i_ascii_mode |->
		o_tx_data inside {[8'h30:8'h39], [8'h41:8'h46]})
		else $error("ascii answer byte not a hex character");
	chk_ready_cause: assert property ($rose(o_rx_ready) |-> $past(i_rx_valid) || $past(i_wr))
		else $error("ready rose without a frame");
	chk_hop_direct: assert property ($past(i_rst_n) && !o_via_router |->
		o_next_hop == $past(i_dest_ip))
		else $error("direct hop differs from destination");
	chk_resp_end: assert property (o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid)
		else $error("bytes after last response byte");
	cover property ($rose(o_tx_valid) && i_ascii_mode);
	cover property (o_tx_valid && !i_tx_ready);
	cover property (o_via_router);
endmodule // rab_props

bind random_access_buffer_server rab_props u_props (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_init_done(i_init_done),
	.i_open_done(i_open_done), .i_proc_exist(i_proc_exist), .i_ascii_mode(i_ascii_mode),
	.i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid),
	.o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .i_dest_ip(i_dest_ip), .o_next_hop(o_next_hop),
	.o_via_router(o_via_router)
);

// *** tb/remote_host.sv ***
`timescale 1ns/1ps
module remote_host (
	// clock
	input wire i_clk,
	input wire i_rst_n,
	// command stream out
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_last,
	input wire i_rx_ready,
	// response stream in
	input wire i_tx_valid,
	input wire [7:0] i_tx_data,
	output logic o_tx_ready
);
	logic [7:0] rsp[$];
	bit slow = 0;
	initial begin
		o_rx_valid = 0;
		o_rx_data = 8'h00;
		o_rx_last = 0;
	end
	// fields
	// frame bytes arrive already coded and ordered; the host only paces them
	task automatic send(input logic [7:0] b[$]);
		int i;
		bit tk;
		i = 0;
		o_rx_valid <= 1;
		o_rx_data <= b[0];
		o_rx_last <= (b.size() == 1);
		while (i < b.size()) begin
			@(negedge i_clk) tk = i_rx_ready;
			@(posedge i_clk);
			if (tk) begin
				i++;
				if (i < b.size()) begin
					o_rx_data <= b[i];
					o_rx_last <= (i == b.size() - 1);
				end else begin
					o_rx_valid <= 0;
					o_rx_last <= 0;
					// released data must not look like the last byte
					o_rx_data <= ~b[i-1];
				end
			end
		end
	endtask
	// ready only changes at posedge, so a negedge look decides the next take
	always @(negedge i_clk) begin
		if (i_tx_valid && o_tx_ready)
			rsp.push_back(i_tx_data);
	end
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_tx_ready <= 0;
		else
			o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
	end
endmodule // remote_host

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	localparam logic [15:0] PB = 16'h0100;
	logic i_ref_clk = 0, i_rst_n = 0, i_ce = 1, i_init_done = 1, i_open_done = 1;
	logic i_proc_exist = 1, i_ascii_mode = 0, i_wr = 0, i_rd = 0;
	logic i_rx_valid, i_rx_last, o_rx_ready, o_tx_valid, o_tx_last, i_tx_ready, o_via_router;
	logic [7:0] i_rx_data, o_tx_data;
	logic [15:0] i_addr = 16'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata, i_dest_ip = 32'h0, o_next_hop;
	logic [7:0] cq[$], eq[$];
	bit am;
	int err_total = 0, checks_done = 0;
	random_access_buffer_server #(.PHYS_BASE(PB)) dut (.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n), .i_ce(i_ce), .i_init_done(i_init_done), .i_open_done(i_open_done),
		.i_proc_exist(i_proc_exist), .i_ascii_mode(i_ascii_mode), .i_rx_valid(i_rx_valid),
		.i_rx_data(i_rx_data), .i_rx_last(i_rx_last), .o_rx_ready(o_rx_ready),
		.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last),
		.i_tx_ready(i_tx_ready), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_dest_ip(i_dest_ip), .o_next_hop(o_next_hop),
		.o_via_router(o_via_router));
	remote_host host (.i_clk(i_ref_clk), .i_rst_n(i_rst_n), .o_rx_valid(i_rx_valid),
		.o_rx_data(i_rx_data), .o_rx_last(i_rx_last), .i_rx_ready(o_rx_ready),
		.i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
	initial begin
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		if (err_total == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_ref_clk) i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk) i_wr <= 0;
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge i_ref_clk) i_rd <= 1;
		i_addr <= a;
		@(posedge i_ref_clk) i_rd <= 0;
		@(negedge i_ref_clk) check(o_rdata, e);
	endtask
	task hop(input logic [31:0] d, input logic [31:0] e, input logic v);
		@(posedge i_ref_clk) i_dest_ip <= d;
		repeat (2) @(posedge i_ref_clk);
		@(negedge i_ref_clk) check({o_via_router, o_next_hop[30:0]}, {v, e[30:0]});
		check(o_next_hop, e);
	endtask
	function logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
	endfunction
	task push(input bit e, input logic [7:0] b);
		if (e)
			eq.push_back(b);
		else
			cq.push_back(b);
	endtask
	task p8(input bit e, input logic [7:0] b);
		if (am) begin
			push(e, hx(b[7:4]));
			push(e, hx(b[3:0]));
		end else
			push(e, b);
	endtask
	task p16(input bit e, input logic [15:0] w);
		p8(e, am ? w[15:8] : w[7:0]);
		p8(e, am ? w[7:0] : w[15:8]);
	endtask
	task hdr(input logic [7:0] sub, input logic [15:0] a, input logic [15:0] n);
		cq.delete();
		eq.delete();
		host.rsp.delete();
		p8(0, sub);
		p8(0, 8'h00);
		p16(0, a);
		p16(0, n);
	endtask
	task go;
		@(posedge i_ref_clk) i_ascii_mode <= am;
		host.send(cq);
	endtask
	task rsp_chk;
		int n;
		n = 0;
		go();
		while (host.rsp.size() < eq.size() && n < 4000) begin
			@(posedge i_ref_clk);
			n++;
		end
		repeat (4) @(posedge i_ref_clk);
		check(32'(host.rsp.size()), 32'(eq.size()));
		for (int i = 0; i < eq.size() && i < host.rsp.size(); i++)
			check({24'h0, host.rsp[i]}, {24'h0, eq[i]});
	endtask
	task t_write_bin;
		am = 0;
		hdr(8'h62, 16'h0014, 16'h0002);
		p16(0, 16'h1234);
		// last word doubles as the completion flag polled by the cpu
		p16(0, 16'h0001);
		p8(1, 8'he2);
		p8(1, 8'h00);
		rsp_chk();
		rd(PB + 16'h0014, 32'h1234);
		rd(PB + 16'h0015, 32'h0001);
		rd(16'hf005, 32'h0);
	endtask
	task t_read_bin;
		wr(PB + 16'h0016, 32'habcd);
		host.slow = 1;
		am = 0;
		hdr(8'h61, 16'h0014, 16'h0003);
		p8(1, 8'he1);
		p8(1, 8'h00);
		p16(1, 16'h1234);
		p16(1, 16'h0001);
		p16(1, 16'habcd);
		rsp_chk();
		host.slow = 0;
	endtask
	task t_refuse;
		for (int k = 0; k < 3; k++) begin
			@(posedge i_ref_clk) {i_init_done, i_open_done, i_proc_exist} <= ~(3'b001 << k);
			am = 0;
			hdr(8'h61, 16'h0014, 16'h0001);
			go();
			repeat (40) @(posedge i_ref_clk);
			check(32'(host.rsp.size()), 32'h0);
			{i_init_done, i_open_done, i_proc_exist} <= 3'b111;
		end
	endtask
	task t_ascii;
		am = 1;
		hdr(8'h62, 16'h0020, 16'h0001);
		p16(0, 16'h5a5a);
		p8(1, 8'he2);
		p8(1, 8'h00);
		rsp_chk();
		hdr(8'h61, 16'h0020, 16'h0001);
		p8(1, 8'he1);
		p8(1, 8'h00);
		p16(1, 16'h5a5a);
		rsp_chk();
		// bad hex character in the text: error code and no buffer write
		hdr(8'h62, 16'h0020, 16'h0001);
		cq.push_back(8'h35);
		cq.push_back(8'h47);
		cq.push_back(8'h35);
		cq.push_back(8'h41);
		p8(1, 8'he2);
		p8(1, 8'h54);
		rsp_chk();
		rd(PB + 16'h0020, 32'h5a5a);
	endtask
	task t_limits;
		am = 0;
		hdr(8'h62, 16'h0014, 16'h03fa);
		p16(0, 16'hdead);
		p8(1, 8'he2);
		p8(1, 8'h51);
		rsp_chk();
		rd(PB + 16'h0014, 32'h1234);
		rd(16'hf005, 32'h51);
		hdr(8'h62, 16'h0014, 16'h03f9);
		p16(0, 16'h1234);
		p8(1, 8'he2);
		p8(1, 8'h00);
		rsp_chk();
		hdr(8'h63, 16'h0014, 16'h0001);
		p8(1, 8'he3);
		p8(1, 8'h53);
		rsp_chk();
		am = 1;
		hdr(8'h62, 16'h0014, 16'h01fd);
		p8(1, 8'he2);
		p8(1, 8'h51);
		rsp_chk();
		hdr(8'h62, 16'h0014, 16'h01fc);
		p8(1, 8'he2);
		p8(1, 8'h00);
		rsp_chk();
		am = 0;
		wr(PB + 16'h0fff, 32'h00a5);
		hdr(8'h61, 16'h0fff, 16'h0001);
		p8(1, 8'he1);
		p8(1, 8'h00);
		p16(1, 16'h00a5);
		rsp_chk();
		hdr(8'h61, 16'h0ffe, 16'h0003);
		p8(1, 8'he1);
		p8(1, 8'h52);
		rsp_chk();
	endtask
	task t_router;
		wr(16'hf000, 32'h1);
		wr(16'hf001, 32'hffff0000);
		wr(16'hf002, 32'hac100001);
		wr(16'hf001, 32'h80000000);
		rd(16'hf001, 32'hffff0000);
		rd(16'hf004, 32'h1);
		wr(16'hf004, 32'h1);
		wr(16'hf003, 32'hffffffff);
		rd(16'hf004, 32'h2);
		wr(16'hf004, 32'h2);
		wr(16'hf003, 32'hac2000fe);
		rd(16'hf004, 32'h2);
		wr(16'hf004, 32'h2);
		wr(16'hf003, 32'hac1000fe);
		rd(16'hf004, 32'h8);
		hop(32'hac100005, 32'hac100005, 0);
		hop(32'h0a000001, 32'hac1000fe, 1);
		wr(16'hf010, 32'h0a000000);
		wr(16'hf011, 32'hac100002);
		hop(32'h0a000001, 32'hac100002, 1);
		rd(16'hf004, 32'h108);
		wr(16'hf012, 32'h0a000001);
		wr(16'hf013, 32'hac100003);
		rd(16'hf004, 32'h10c);
		rd(16'hf006, 32'h0);
		wr(16'hf000, 32'h0);
		// a write while the clock enable is low must not land
		@(posedge i_ref_clk) i_ce <= 0;
		wr(16'hf000, 32'h1);
		@(posedge i_ref_clk) i_ce <= 1;
		rd(16'hf000, 32'h0);
		hop(32'h0a000001, 32'h0a000001, 0);
	endtask
	initial begin
		repeat (5) @(posedge i_ref_clk);
		i_rst_n <= 1;
		t_write_bin();
		t_read_bin();
		t_refuse();
		t_ascii();
		t_limits();
		t_router();
		complete_run();
	end
	initial begin
		#200000;
		err_total++;
		complete_run();
	end
endmodule // tb_top
